/* File: design/adc_defs.svh */
// Constants for the converter and amplifier control block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ 20000000
`define SAMPLE_RATE_SPS 120000
`define CONV_PERIOD_CYC (`CLK_HZ / `SAMPLE_RATE_SPS)
`define CONV_TICKS 13
`define CONV_DIV_CYC (`CONV_PERIOD_CYC / `CONV_TICKS)
`define SAMPLE_TICKS 2
`define RES_BITS 10
`define REF_INTERNAL_MV 2560

// ----------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------
`define OFS_CONV_CTRL 8'h00
`define OFS_CHAN_SEL 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_AMP_CSR 8'h10

// ----------------------------------------------------------------------
// Reset values, masks and fields
// ----------------------------------------------------------------------
`define AMP_CSR_RESET 8'h00
`define AMP_CSR_WMASK 8'hFB
`define CONV_CTRL_RESET 6'h00
`define CHAN_RESET 4'h0
`define NUM_SE_CHANNELS 4'hB
`define DIFF_CHANNEL 4'hB
`define BIT_START 6
`define BIT_DONE 4
`define CHAN_LSB 0
`define TSRC_LSB 4

`endif

/* File: design/adc_pkg.sv */
// Types shared by the converter control files
package adc_pkg;

	typedef enum logic [1:0] {
		GAIN_X5,
		GAIN_X10,
		GAIN_X20,
		GAIN_X40
	} amp_gain_t;

	typedef struct packed {
		logic en;
		logic shunt;
		amp_gain_t gain;
		logic gnd_sel;
		logic rsvd;
		logic [1:0] trig_sel;
	} amp_ctl_t;

	typedef struct packed {
		logic enable;
		logic auto_trig;
		logic irq_en;
		logic left_adj;
		logic ref_internal;
		logic free_run;
	} conv_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT
	} conv_state_t;

endpackage

/* File: design/sar_engine.sv */
// Successive-approximation sequencer with its conversion clock divider
`timescale 1ns/10ps
`default_nettype none
`include "adc_defs.svh"

module sar_engine #(
	parameter int RES_W = `RES_BITS,
	parameter int DIV = `CONV_DIV_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic comp_in,
	output logic busy_q,
	output logic done_q,
	output logic tick_q,
	output logic hold_q,
	output logic [RES_W-1:0] dac_q,
	output logic [RES_W-1:0] result_q
);
	localparam int CW = $clog2(DIV + 1);
	localparam int IW = $clog2(RES_W + 1);
	localparam int MAX_CONV = `CONV_PERIOD_CYC;

	function automatic logic [RES_W-1:0] with_bit(
		input logic [RES_W-1:0] v, input logic [IW-1:0] i);
		with_bit = v | (RES_W'(1) << i);
	endfunction

	adc_pkg::conv_state_t state_q;
	logic [CW-1:0] div_q;
	logic [IW-1:0] idx_q;
	logic tick_d;
	logic [RES_W-1:0] keep;

	// ------------------------------------------------------------------
	// Conversion clock: free-running one-cycle enable
	// ------------------------------------------------------------------
	assign tick_d = (div_q == CW'(DIV - 1));
	// Comparator high means input at or above the trial code
	assign keep = comp_in ? dac_q : (dac_q & ~(RES_W'(1) << idx_q));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= tick_d ? '0 : CW'(div_q + 1'b1);
			tick_q <= tick_d;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= adc_pkg::ST_IDLE;
			idx_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			hold_q <= 1'b0;
			dac_q <= '0;
			result_q <= '0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
			adc_pkg::ST_IDLE: begin
				if (start) begin
					state_q <= adc_pkg::ST_SAMPLE;
					busy_q <= 1'b1;
					hold_q <= 1'b1;
					idx_q <= '0;
				end
			end
			adc_pkg::ST_SAMPLE: begin
				if (tick_d) begin
					idx_q <= IW'(idx_q + 1'b1);
					if (idx_q == IW'(`SAMPLE_TICKS - 1)) begin
						state_q <= adc_pkg::ST_CONVERT;
						hold_q <= 1'b0;
						idx_q <= IW'(RES_W - 1);
						dac_q <= with_bit('0, IW'(RES_W - 1));
					end
				end
			end
			adc_pkg::ST_CONVERT: begin
				if (tick_d) begin
					if (idx_q == '0) begin
						result_q <= keep;
						done_q <= 1'b1;
						busy_q <= 1'b0;
						dac_q <= '0;
						state_q <= adc_pkg::ST_IDLE;
					end else begin
						dac_q <= with_bit(keep, IW'(idx_q - 1'b1));
						idx_q <= IW'(idx_q - 1'b1);
					end
				end
			end
			default: begin
				state_q <= adc_pkg::ST_IDLE;
				busy_q <= 1'b0;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [IW-1:0] trials_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trials_q <= '0;
		end else if (state_q == adc_pkg::ST_IDLE) begin
			trials_q <= '0;
		end else if (tick_d && state_q == adc_pkg::ST_CONVERT) begin
			trials_q <= IW'(trials_q + 1'b1);
		end
	end

	chk_bit_trials: assert property (@(posedge clk) disable iff (!resetn)
		done_q |-> trials_q == IW'(RES_W))
		else $error("conversion did not take one trial per bit");

	chk_conv_pace: assert property (@(posedge clk) disable iff (!resetn)
		$rose(busy_q) |-> ##[1:MAX_CONV] done_q)
		else $error("conversion slower than the sample rate allows");

endmodule

`default_nettype wire

/* File: design/adc_amplifier_control.sv */
// Converter and amplifier control with a Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
`include "adc_defs.svh"

module adc_amplifier_control #(
	parameter int CONV_DIV = `CONV_DIV_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic comp_in,
	input wire logic [3:0] trig_events,
	input wire logic [2:0] amp_sync_events,
	output logic conv_irq,
	output logic [3:0] mux_sel,
	output logic ref_internal,
	output logic amp_enable,
	output logic amp_input_shunt,
	output logic [1:0] amp_gain_sel,
	output logic amp_gnd_switch,
	output logic amp_negative_input_pin_connect,
	output logic amp_sample,
	output logic sample_hold,
	output logic [9:0] dac_code
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	adc_pkg::conv_ctl_t ctl_q;
	adc_pkg::amp_ctl_t amp_q;
	logic done_q;
	logic [3:0] chan_q;
	logic [1:0] tsrc_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic [3:0] trig_prev_q;
	logic [2:0] sync_prev_q;
	logic busy;
	logic sar_done;
	logic sar_tick;
	logic [9:0] sar_result;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	wire hit_ctl = hit(wb_adr_i, `OFS_CONV_CTRL);
	wire hit_chan = hit(wb_adr_i, `OFS_CHAN_SEL);
	wire hit_hi = hit(wb_adr_i, `OFS_RESULT_HIGH);
	wire hit_lo = hit(wb_adr_i, `OFS_RESULT_LOW);
	wire hit_amp = hit(wb_adr_i, `OFS_AMP_CSR);
	wire wr_ctl = wr & hit_ctl;
	wire wr_amp = wr & hit_amp;
	wire [7:0] ctl_rd = {ctl_q.enable, busy, ctl_q.auto_trig, done_q,
		ctl_q.irq_en, ctl_q.left_adj, ctl_q.ref_internal, ctl_q.free_run};
	wire [7:0] rd_byte = hit_ctl ? ctl_rd :
		hit_chan ? {2'h0, tsrc_q, chan_q} :
		hit_hi ? res_hi_q :
		hit_lo ? res_lo_q :
		hit_amp ? (amp_q & `AMP_CSR_WMASK) : 8'h00;

	// ------------------------------------------------------------------
	// Start sources
	// ------------------------------------------------------------------
	// Start writes while busy are dropped, not queued
	wire sw_start = wr_ctl & wd[`BIT_START];
	wire [3:0] trig_rise = trig_events & ~trig_prev_q;
	wire auto_start = ctl_q.auto_trig & trig_rise[tsrc_q];
	wire run_start = ctl_q.free_run & sar_done;
	wire start = ctl_q.enable & ~busy & (sw_start | auto_start | run_start);
	wire clr_done = wr_ctl & wd[`BIT_DONE];
	wire [2:0] sync_rise = amp_sync_events & ~sync_prev_q;
	wire [3:0] amp_src = {sync_rise, sar_tick};
	wire chan_ok = wd[3:0] <= `DIFF_CHANNEL;
	wire [7:0] hi_right = {6'h00, sar_result[9:8]};
	wire [7:0] lo_left = {sar_result[1:0], 6'h00};
	wire [7:0] hi_d = ctl_q.left_adj ? sar_result[9:2] : hi_right;
	wire [7:0] lo_d = ctl_q.left_adj ? lo_left : sar_result[7:0];
	// Clearing waits for the running conversion to end
	wire amp_en_d = amp_q.en | (amp_enable & busy);

	// ------------------------------------------------------------------
	// Bus slave: one-cycle ack, zero for unmapped reads
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_q <= `CONV_CTRL_RESET;
			chan_q <= `CHAN_RESET;
			tsrc_q <= 2'h0;
			amp_q <= `AMP_CSR_RESET;
		end else begin
			if (wr_ctl) begin
				ctl_q <= {wd[7], wd[5], wd[3:0]};
			end
			if (wr & hit_chan & chan_ok) begin
				chan_q <= wd[`CHAN_LSB +: 4];
			end
			if (wr & hit_chan) begin
				tsrc_q <= wd[`TSRC_LSB +: 2];
			end
			if (wr_amp) begin
				amp_q <= adc_pkg::amp_ctl_t'(wd & `AMP_CSR_WMASK);
			end
		end
	end

	// ------------------------------------------------------------------
	// Status, results and edge history
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
			res_hi_q <= 8'h00;
			res_lo_q <= 8'h00;
			trig_prev_q <= 4'h0;
			sync_prev_q <= 3'h0;
			conv_irq <= 1'b0;
		end else begin
			done_q <= sar_done | (done_q & ~clr_done);
			conv_irq <= ctl_q.irq_en & (sar_done | (done_q & ~clr_done));
			if (sar_done) begin
				res_hi_q <= hi_d;
				res_lo_q <= lo_d;
			end
			trig_prev_q <= trig_events;
			sync_prev_q <= amp_sync_events;
		end
	end

	// ------------------------------------------------------------------
	// Analog side controls
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mux_sel <= `CHAN_RESET;
			ref_internal <= 1'b0;
			amp_enable <= 1'b0;
			amp_input_shunt <= 1'b0;
			amp_gain_sel <= adc_pkg::GAIN_X5;
			amp_gnd_switch <= 1'b0;
			amp_negative_input_pin_connect <= 1'b1;
			amp_sample <= 1'b0;
		end else begin
			mux_sel <= chan_q;
			ref_internal <= ctl_q.ref_internal;
			amp_enable <= amp_en_d;
			amp_input_shunt <= amp_q.shunt;
			amp_gain_sel <= amp_q.gain;
			amp_gnd_switch <= amp_q.gnd_sel & ~amp_q.shunt;
			amp_negative_input_pin_connect <= ~amp_q.gnd_sel;
			amp_sample <= amp_enable & amp_src[amp_q.trig_sel];
		end
	end

	sar_engine #(
		.RES_W(`RES_BITS),
		.DIV(CONV_DIV)
	) u_sar (
		.clk(clk),
		.resetn(resetn),
		.start(start),
		.comp_in(comp_in),
		.busy_q(busy),
		.done_q(sar_done),
		.tick_q(sar_tick),
		.hold_q(sample_hold),
		.dac_q(dac_code),
		.result_q(sar_result)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_amp_cleared;
		!amp_q.en && busy;
	endsequence

	chk_ack_single: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	chk_amp_enable_on: assert property (
		wr_amp && wd[7] |=> ##1 amp_enable)
		else $error("amplifier not enabled after write");

	chk_amp_hold_busy: assert property (
		s_amp_cleared ##0 amp_enable |=> amp_enable)
		else $error("amplifier disabled during a conversion");

	chk_amp_off_idle: assert property (
		!amp_q.en && !busy |=> !amp_enable)
		else $error("amplifier stays on with nothing running");

	chk_ground_release: assert property (
		amp_input_shunt && !amp_negative_input_pin_connect
		|-> !amp_gnd_switch)
		else $error("ground switch closed during shunt");

	chk_neg_pin_cut: assert property (
		amp_gnd_switch |-> !amp_negative_input_pin_connect)
		else $error("negative pin connected while grounded");

	chk_done_sticky: assert property (
		sar_done |=> done_q)
		else $error("completion lost");

	chk_irq_follow: assert property (
		sar_done && ctl_q.irq_en |=> conv_irq)
		else $error("no interrupt on completion");

	chk_left_adjust: assert property (
		sar_done && ctl_q.left_adj |=> {res_hi_q, res_lo_q[7:6]}
		== $past(sar_result) && res_lo_q[5:0] == 6'h00)
		else $error("left-adjusted result misplaced");

	chk_free_run: assert property (
		sar_done && ctl_q.free_run && ctl_q.enable |=> busy)
		else $error("free-running conversion did not restart");

	chk_result_split: assert property (
		sar_done && !ctl_q.left_adj |=> {res_hi_q[1:0], res_lo_q}
		== $past(sar_result))
		else $error("right-adjusted result misplaced");

	sequence s_start_ok;
		ctl_q.enable && !busy;
	endsequence

	chk_auto_start: assert property (
		s_start_ok ##0 auto_start |=> busy)
		else $error("trigger event did not start a conversion");

	chk_sw_start: assert property (
		s_start_ok ##0 sw_start |=> busy)
		else $error("start write did not start a conversion");

	chk_no_restart: assert property (
		sar_done && !ctl_q.enable |=> !busy)
		else $error("conversion started while disabled");

	chk_chan_guard: assert property (
		wr && hit_chan && !chan_ok |=> $stable(chan_q))
		else $error("out of range channel accepted");

	chk_chan_route: assert property (
		wr && hit_chan && chan_ok |=> ##1 mux_sel == $past(chan_q))
		else $error("channel select not routed to the multiplexer");

	chk_ref_route: assert property (
		wr_ctl |=> ##1 ref_internal == ctl_q.ref_internal)
		else $error("reference select not routed");

	chk_shunt_route: assert property (
		wr_amp |=> ##1 amp_input_shunt == amp_q.shunt)
		else $error("input shunt not routed");

	chk_gain_route: assert property (
		wr_amp |=> ##1 amp_gain_sel == amp_q.gain)
		else $error("gain code not routed");

	chk_sample_gate: assert property (
		!amp_enable |=> !amp_sample)
		else $error("amplifier sampled while disabled");

	chk_sample_tick: assert property (
		amp_enable && amp_q.trig_sel == 2'h0 && sar_tick |=> amp_sample)
		else $error("amplifier did not sample on the converter clock");

	chk_unmapped_read: assert property (
		req && !wb_we_i && !(hit_ctl || hit_chan || hit_hi || hit_lo
		|| hit_amp) |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	chk_done_clear: assert property (
		clr_done && !sar_done |=> !done_q)
		else $error("completion flag not cleared");

	chk_result_hold: assert property (
		!sar_done |=> $stable(res_hi_q) && $stable(res_lo_q))
		else $error("result changed without a completion");

endmodule

`default_nettype wire

/* File: test/analog_source.sv */
// Analog input and trigger source model facing the converter
`timescale 1ns/10ps
`default_nettype none

module analog_source (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] level,
	input wire logic fire,
	output logic comp_in,
	output logic [3:0] trig_events,
	output logic [2:0] amp_sync_events
);
	// ------------------------------------------------------------------
	// Comparator and event sources
	// ------------------------------------------------------------------
	logic [2:0] sync_q;
	// Ideal comparator, no offset; a noisy one would blur the last bit
	assign comp_in = (level >= dac_code);
	assign amp_sync_events = sync_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_q <= 3'h0;
			trig_events <= 4'h0;
		end else begin
			sync_q <= sync_q + 3'h1;
			trig_events <= {3'h0, fire};
		end
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Register-level testbench for the converter and amplifier control
`timescale 1ns/10ps
`default_nettype none
`include "adc_defs.svh"

module tb;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic clk, resetn, we, cyc, stb, fire, comp_in, conv_irq, ref_internal;
	logic amp_enable, amp_input_shunt, amp_gnd_switch, conn, wb_ack_o;
	logic [7:0] adr;
	logic [31:0] dat, wb_dat_o, q;
	logic [3:0] sel, trig_events, mux_sel;
	logic [2:0] amp_sync_events;
	logic [1:0] amp_gain_sel;
	logic [9:0] dac_code, level;
	logic amp_sample, sample_hold;
	int n_errors, checks, cycles, pulses;

	adc_amplifier_control #(.CONV_DIV(2)) u_adc_amplifier_control (
		.clk(clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_in(comp_in),
		.trig_events(trig_events), .amp_sync_events(amp_sync_events),
		.conv_irq(conv_irq), .mux_sel(mux_sel), .ref_internal(ref_internal),
		.amp_enable(amp_enable), .amp_input_shunt(amp_input_shunt),
		.amp_gain_sel(amp_gain_sel), .amp_gnd_switch(amp_gnd_switch),
		.amp_negative_input_pin_connect(conn),
		.amp_sample(amp_sample), .sample_hold(sample_hold),
		.dac_code(dac_code));

	analog_source u_analog_source (
		.clk(clk), .resetn(resetn), .dac_code(dac_code), .level(level),
		.fire(fire), .comp_in(comp_in), .trig_events(trig_events),
		.amp_sync_events(amp_sync_events));

	// ------------------------------------------------------------------
	// Clock, timeout and tasks
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude;
		$display("Counts: %0d errors in %0d checks", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{cyc, stb, we} <= 3'b000;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic wait_irq;
		while (conv_irq !== 1'b1) @(posedge clk);
		settle();
	endtask

	task automatic result(input logic [7:0] hi, input logic [7:0] lo);
		xfer(1'b0, `OFS_RESULT_HIGH, 8'h00);
		chk(q, {24'h0, hi});
		xfer(1'b0, `OFS_RESULT_LOW, 8'h00);
		chk(q, {24'h0, lo});
	endtask

	task automatic count_pulses(input int n);
		pulses = 0;
		repeat (n) begin
			@(posedge clk);
			if (amp_sample === 1'b1)
				pulses++;
		end
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{resetn, we, cyc, stb, fire, adr, dat} = '0;
		sel = 4'h1;
		level = 10'h2D5;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk(amp_enable, 1'b0);
		chk(conn, 1'b1);
		xfer(1'b0, `OFS_AMP_CSR, 8'h00);
		chk(q, 32'h0);
		xfer(1'b0, 8'h14, 8'h00);
		chk(q, 32'h0);
		for (int g = 0; g < 4; g++) begin
			xfer(1'b1, `OFS_AMP_CSR, 8'h88 | (g << 4));
			settle();
			chk(amp_enable, 1'b1);
			chk(amp_gain_sel, g[1:0]);
			chk({amp_input_shunt, amp_gnd_switch, conn}, 3'b010);
		end
		xfer(1'b1, `OFS_AMP_CSR, 8'hFF);
		xfer(1'b0, `OFS_AMP_CSR, 8'h00);
		chk(q, 32'hFB);
		settle();
		chk({amp_input_shunt, amp_gnd_switch}, 2'b10);
		xfer(1'b1, `OFS_AMP_CSR, 8'h80);
		settle();
		chk({amp_input_shunt, conn}, 2'b01);
		count_pulses(20);
		chk(pulses, 10);
		xfer(1'b1, `OFS_AMP_CSR, 8'h83);
		settle();
		count_pulses(16);
		chk(pulses, 2);
		xfer(1'b1, `OFS_CHAN_SEL, 8'h0A);
		xfer(1'b1, `OFS_CHAN_SEL, 8'h0C);
		settle();
		chk(mux_sel, 4'hA);
		// Single conversion, right then left adjusted
		// Enable first: a start in the enabling write is ignored
		xfer(1'b1, `OFS_CONV_CTRL, 8'h8A);
		xfer(1'b1, `OFS_CONV_CTRL, 8'hCA);
		chk({sample_hold, dac_code}, 11'h400);
		settle();
		chk(ref_internal, 1'b1);
		wait_irq();
		chk(conv_irq, 1'b1);
		result(8'h02, 8'hD5);
		xfer(1'b1, `OFS_CONV_CTRL, 8'h98);
		settle();
		chk(conv_irq, 1'b0);
		xfer(1'b1, `OFS_CONV_CTRL, 8'hCC);
		wait_irq();
		result(8'hB5, 8'h40);
		xfer(1'b1, `OFS_CONV_CTRL, 8'h98);
		// Amplified channel; disable requested mid-conversion
		xfer(1'b1, `OFS_CHAN_SEL, 8'h0B);
		xfer(1'b1, `OFS_CONV_CTRL, 8'hC8);
		xfer(1'b1, `OFS_AMP_CSR, 8'h00);
		settle();
		chk({mux_sel, amp_enable}, 5'h17);
		wait_irq();
		chk(amp_enable, 1'b0);
		count_pulses(8);
		chk(pulses, 0);
		// First amplified result is left unread as noisy
		xfer(1'b1, `OFS_CONV_CTRL, 8'h98);
		// Trigger source 0 starts a conversion without software
		level <= 10'h3FF;
		xfer(1'b1, `OFS_CONV_CTRL, 8'hA8);
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wait_irq();
		result(8'h03, 8'hFF);
		xfer(1'b1, `OFS_CONV_CTRL, 8'h98);
		// Free running: a second result with one start only
		level <= 10'h001;
		xfer(1'b1, `OFS_CONV_CTRL, 8'hC9);
		wait_irq();
		xfer(1'b1, `OFS_CONV_CTRL, 8'h99);
		wait_irq();
		xfer(1'b0, `OFS_CONV_CTRL, 8'h00);
		chk(q & 32'h50, 32'h50);
		result(8'h00, 8'h01);
		xfer(1'b1, `OFS_CONV_CTRL, 8'h10);
		conclude();
	end
endmodule
`default_nettype wire
